/* File: common/cpu_slice_pkg.sv */
package cpu_slice_pkg;

  // ----------------------------------------------------------------
  // Opcode map
  // ----------------------------------------------------------------
  localparam logic [3:0] GRP_BIT_BRANCH  = 4'h0;   // Test bit, branch
  localparam logic [3:0] GRP_BIT_SETCLR  = 4'h1;   // Set or clear bit
  localparam logic [3:0] GRP_REL_BRANCH  = 4'h2;   // Relative branches
  localparam logic [7:0] OP_SHL_DIR      = 8'h38;
  localparam logic [7:0] OP_SHL_ACC      = 8'h48;
  localparam logic [7:0] OP_SHL_IDX      = 8'h58;
  localparam logic [7:0] OP_SHL_IX1      = 8'h68;
  localparam logic [7:0] OP_SHL_IX       = 8'h78;
  localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97;
  localparam logic [7:0] OP_STOP         = 8'h8E;
  localparam logic [7:0] OP_WAIT         = 8'h8F;

  // Opcode fields
  localparam int GROUP_MSB    = 7;
  localparam int GROUP_LSB    = 4;
  localparam int BITNUM_MSB   = 3;
  localparam int BITNUM_LSB   = 1;
  localparam int POLARITY_BIT = 0;                 // 0: set/high, 1: clear/low

  // ----------------------------------------------------------------
  // Addressing and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  DIRECT_PAGE_HIGH = 8'h00;
  localparam logic [15:0] RESET_PC         = 16'h0000;
  localparam logic [7:0]  BIT_ONE          = 8'h01;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ccr_s;

  localparam ccr_s CCR_RESET = 5'h08;             // Interrupt mask set

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_DECODE  = 4'h1,
    S_OPND    = 4'h2,
    S_INDEX   = 4'h3,
    S_MEMRD   = 4'h4,
    S_OFFS    = 4'h5,
    S_WRITE   = 4'h6,
    S_EXEC    = 4'h7,
    S_RESOLVE = 4'h8,
    S_LOWPWR  = 4'h9
  } core_state_e;

  // ----------------------------------------------------------------
  // Register bus map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_CCR    = 8'h0C;
  localparam logic [7:0] OFS_ACC    = 8'h10;
  localparam logic [7:0] OFS_IDX    = 8'h14;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_WAKE_BIT  = 1;
  localparam int CTRL_CLRBAD_BIT = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ----------------------------------------------------------------
  // Opcode class decoding
  // ----------------------------------------------------------------
  function automatic logic is_bit_branch(input logic [7:0] op);
    return op[GROUP_MSB:GROUP_LSB] == GRP_BIT_BRANCH;
  endfunction : is_bit_branch

  function automatic logic is_bit_setclr(input logic [7:0] op);
    return op[GROUP_MSB:GROUP_LSB] == GRP_BIT_SETCLR;
  endfunction : is_bit_setclr

  function automatic logic is_rel_branch(input logic [7:0] op);
    return op[GROUP_MSB:GROUP_LSB] == GRP_REL_BRANCH;
  endfunction : is_rel_branch

endpackage : cpu_slice_pkg

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser for a level coming from a pin
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,     // Core clock
  input  wire logic rst_n_i,   // Async reset, active low
  input  wire logic async_i,   // Raw pin level
  output logic      sync_o     // Level safe to use
);

  logic meta_reg;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage is read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_VAL;
      sync_o   <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : pin_sync

/* File: hw/exec_unit.sv */
`timescale 1ns/1ps

// Shift, bit and branch-condition datapath
module exec_unit
  import cpu_slice_pkg::*;
(
  input  wire logic [7:0] op_i,         // Opcode
  input  wire logic [7:0] data_i,       // Operand value
  input  ccr_s            ccr_i,        // Current flags
  input  wire logic       irq_level_i,  // Synchronised pin level
  output logic [7:0]      shl_o,        // Shifted value
  output ccr_s            shl_flags_o,  // Flags after shift
  output logic            bit_val_o,    // Selected operand bit
  output logic [7:0]      bit_mod_o,    // Operand with bit set/cleared
  output logic            taken_o       // Branch condition met
);

  logic [2:0] bit_num;
  logic [7:0] bit_mask;
  logic [7:0] pair_true;
  logic       flip;

  // ----------------------------------------------------------------
  // Bit position and polarity
  // ----------------------------------------------------------------
  // Both come from the opcode only
  assign bit_num   = op_i[BITNUM_MSB:BITNUM_LSB];
  assign flip      = op_i[POLARITY_BIT];
  assign bit_mask  = BIT_ONE << bit_num;
  assign bit_val_o = data_i[bit_num];
  assign bit_mod_o = flip ? (data_i & ~bit_mask) : (data_i | bit_mask);

  // ----------------------------------------------------------------
  // Shift left, flags N Z C; H and I kept
  // ----------------------------------------------------------------
  assign shl_o         = {data_i[6:0], 1'b0};
  assign shl_flags_o.h = ccr_i.h;
  assign shl_flags_o.i = ccr_i.i;
  assign shl_flags_o.n = shl_o[7];
  assign shl_flags_o.z = (shl_o == '0);
  assign shl_flags_o.c = data_i[7];

  // ----------------------------------------------------------------
  // Branch condition, even opcode of each pair tests true
  // ----------------------------------------------------------------
  // Pairs: always, higher, carry zero, not equal, half carry zero,
  // plus, mask clear, pin low; odd opcode inverts the pair's test
  assign pair_true = {~irq_level_i, ~ccr_i.i, ~ccr_i.n, ~ccr_i.h,
                      ~ccr_i.z, ~ccr_i.c, ~(ccr_i.c | ccr_i.z), 1'b1};

  // Bit tests use carry, which already holds the tested bit
  assign taken_o = is_rel_branch(op_i) ? (pair_true[bit_num] ^ flip)
                 : is_bit_branch(op_i) ? (ccr_i.c ^ flip)
                 : 1'b0;

endmodule : exec_unit

/* File: hw/branch_bit_control_decode.sv */
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module branch_bit_control_decode
  import cpu_slice_pkg::*;
#(
  parameter logic [15:0] START_PC = RESET_PC
) (
  input  wire logic        CLOCK_I,        // 200 MHz core clock
  input  wire logic        RESETN_I,       // Async reset, active low
  input  wire logic        HSEL_I,         // Slave select
  input  wire logic [31:0] HADDR_I,        // Byte address
  input  wire logic [1:0]  HTRANS_I,       // Transfer type
  input  wire logic        HWRITE_I,       // Write when high
  input  wire logic [2:0]  HSIZE_I,        // Transfer size
  input  wire logic [31:0] HWDATA_I,       // Write data
  input  wire logic        HREADY_I,       // Bus ready
  output logic [31:0]      HRDATA_O,       // Read data
  output logic             HREADYOUT_O,    // Slave ready
  output logic             HRESP_O,        // Always OKAY
  output logic [15:0]      MEM_ADDR_O,     // Memory address
  output logic             MEM_RD_O,       // Read strobe
  output logic             MEM_WR_O,       // Write strobe
  output logic [7:0]       MEM_WDATA_O,    // Write data
  input  wire logic [7:0]  MEM_RDATA_I,    // Read data, same cycle
  input  wire logic        IRQ_PIN_I,      // Interrupt pin, active low
  output logic             OSC_STOP_O,     // Oscillator halted
  output logic             CPU_CLK_STOP_O, // CPU clock halted
  output logic             IRQ_ENABLE_O    // Interrupts unmasked
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  core_state_e state_reg, state_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0]  acc_reg, acc_next;
  logic [7:0]  idx_reg, idx_next;
  ccr_s        ccr_reg, ccr_next;
  logic [7:0]  op_reg, op_next;
  logic [15:0] ea_reg, ea_next;
  logic [7:0]  data_reg, data_next;
  mem_req_s    mem_reg, mem_next;
  logic        osc_stop_reg, osc_stop_next;
  logic        clk_stop_reg, clk_stop_next;
  logic        irq_en_reg;
  logic        run_reg, run_next;
  logic        bad_reg, bad_next;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;

  // Datapath wires
  logic        irq_level;
  logic [7:0]  cur_op;
  logic [7:0]  alu_data;
  logic [7:0]  shl_res;
  ccr_s        shl_flags;
  logic        bit_val;
  logic [7:0]  bit_mod;
  logic        taken;
  logic [8:0]  ix1_sum;
  logic [15:0] branch_target;
  logic [15:0] direct_ea;
  logic        needs_opnd;
  logic        direct_mem;
  logic        is_shl_mem;
  logic        wake;
  // Bus wires
  logic        bus_take;
  logic [31:0] rd_word;
  logic        sw_wr;
  logic        sw_core_wr;
  logic        ctrl_wr;
  logic        bad_set;
  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_irq_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESETN_I),
    .async_i (IRQ_PIN_I),
    .sync_o  (irq_level)
  );

  exec_unit u_exec (
    .op_i        (op_reg),
    .data_i      (alu_data),
    .ccr_i       (ccr_reg),
    .irq_level_i (irq_level),
    .shl_o       (shl_res),
    .shl_flags_o (shl_flags),
    .bit_val_o   (bit_val),
    .bit_mod_o   (bit_mod),
    .taken_o     (taken)
  );

  // ----------------------------------------------------------------
  // Decode and address forming
  // ----------------------------------------------------------------
  // Opcode arrives on the bus during decode, later it is held
  assign cur_op     = (state_reg == S_DECODE) ? MEM_RDATA_I : op_reg;
  assign is_shl_mem = (cur_op == OP_SHL_DIR) || (cur_op == OP_SHL_IX1)
                   || (cur_op == OP_SHL_IX);
  assign direct_mem = is_bit_branch(cur_op) || is_bit_setclr(cur_op)
                   || (cur_op == OP_SHL_DIR);
  assign needs_opnd = direct_mem || is_rel_branch(cur_op) || (cur_op == OP_SHL_IX1);
  assign direct_ea  = {DIRECT_PAGE_HIGH, MEM_RDATA_I};
  assign ix1_sum    = {1'b0, idx_reg} + {1'b0, data_reg};
  // Offset sign-extended before the add
  assign branch_target = pc_reg + {{8{data_reg[7]}}, data_reg};
  assign alu_data   = (state_reg == S_MEMRD) ? MEM_RDATA_I
                    : (op_reg == OP_SHL_IDX) ? idx_reg : acc_reg;
  // Pin is active low; an unmasked pin request or a CTRL wake-bit write wakes the core
  assign wake       = (~irq_level && ~ccr_reg.i) || (ctrl_wr && HWDATA_I[CTRL_WAKE_BIT]);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  assign bus_take   = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ)
                   && (HSIZE_I == HSIZE_WORD);
  assign sw_wr      = wr_pend_reg;
  // Core registers only take bus writes while the core is parked
  assign sw_core_wr = sw_wr && (state_reg == S_IDLE);
  assign ctrl_wr    = sw_wr && (wr_addr_reg == OFS_CTRL);
  assign rd_word    = (HADDR_I[7:0] == OFS_CTRL)   ? 32'(run_reg)
                    : (HADDR_I[7:0] == OFS_STATUS) ? 32'({op_reg, 4'h0, bad_reg,
                                                         clk_stop_reg, osc_stop_reg,
                                                         state_reg != S_IDLE})
                    : (HADDR_I[7:0] == OFS_PC)     ? 32'(pc_reg)
                    : (HADDR_I[7:0] == OFS_CCR)    ? 32'(ccr_reg)
                    : (HADDR_I[7:0] == OFS_ACC)    ? 32'(acc_reg)
                    : (HADDR_I[7:0] == OFS_IDX)    ? 32'(idx_reg)
                    : 32'h00000000;

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    pc_next       = pc_reg;
    acc_next      = acc_reg;
    idx_next      = idx_reg;
    ccr_next      = ccr_reg;
    op_next       = op_reg;
    ea_next       = ea_reg;
    data_next     = data_reg;
    mem_next      = mem_reg;
    mem_next.rd   = 1'b0;
    mem_next.wr   = 1'b0;
    osc_stop_next = osc_stop_reg;
    clk_stop_next = clk_stop_reg;
    bad_set       = 1'b0;
    case (state_reg)
      S_IDLE: begin
        // Fetch straight away, so a stale branch in op_reg is never replayed
        if (run_reg) begin
          mem_next.rd   = 1'b1;
          mem_next.addr = pc_reg;
          state_next    = S_DECODE;
        end
      end
      S_DECODE: begin
        op_next = cur_op;
        pc_next = pc_reg + 16'h0001;
        if (needs_opnd) begin
          mem_next.rd   = 1'b1;
          mem_next.addr = pc_reg + 16'h0001;
          state_next    = S_OPND;
        end else if (cur_op == OP_SHL_IX) begin
          state_next = S_INDEX;
        end else begin
          state_next = S_EXEC;
        end
      end
      S_OPND: begin
        pc_next   = pc_reg + 16'h0001;
        data_next = MEM_RDATA_I;
        if (direct_mem) begin
          // Second byte is the direct address of the operand
          ea_next       = direct_ea;
          mem_next.rd   = 1'b1;
          mem_next.addr = direct_ea;
          state_next    = S_MEMRD;
        end else if (cur_op == OP_SHL_IX1) begin
          state_next = S_INDEX;
        end else begin
          state_next = S_RESOLVE;
        end
      end
      S_INDEX: begin
        ea_next       = (op_reg == OP_SHL_IX1) ? 16'(ix1_sum) : {DIRECT_PAGE_HIGH, idx_reg};
        mem_next.rd   = 1'b1;
        mem_next.addr = ea_next;
        state_next    = S_MEMRD;
      end
      S_MEMRD: begin
        data_next = MEM_RDATA_I;
        if (is_bit_branch(op_reg)) begin
          ccr_next.c    = bit_val;
          mem_next.rd   = 1'b1;
          mem_next.addr = pc_reg;
          state_next    = S_OFFS;
        end else begin
          // Read-modify-write of the addressed byte
          mem_next.wr    = 1'b1;
          mem_next.addr  = ea_reg;
          mem_next.wdata = is_bit_setclr(op_reg) ? bit_mod : shl_res;
          if (is_shl_mem) begin
            ccr_next = shl_flags;
          end
          state_next = S_WRITE;
        end
      end
      S_OFFS: begin
        pc_next    = pc_reg + 16'h0001;
        data_next  = MEM_RDATA_I;
        state_next = S_RESOLVE;
      end
      S_WRITE: begin
        state_next = S_RESOLVE;
      end
      S_EXEC: begin
        state_next = S_RESOLVE;
        case (op_reg)
          OP_SHL_ACC: begin
            acc_next = shl_res;
            ccr_next = shl_flags;
          end
          OP_SHL_IDX: begin
            idx_next = shl_res;
            ccr_next = shl_flags;
          end
          OP_ACC_TO_INDEX: begin
            idx_next = acc_reg;
          end
          OP_STOP: begin
            osc_stop_next = 1'b1;
            ccr_next.i    = 1'b0;
            state_next    = S_LOWPWR;
          end
          OP_WAIT: begin
            clk_stop_next = 1'b1;
            ccr_next.i    = 1'b0;
            state_next    = S_LOWPWR;
          end
          default: begin
            bad_set = 1'b1;
          end
        endcase
      end
      S_RESOLVE: begin
        // Flags are not touched here, taken or not
        if ((is_rel_branch(op_reg) || is_bit_branch(op_reg)) && taken) begin
          pc_next = branch_target;
        end
        if (run_reg) begin
          mem_next.rd   = 1'b1;
          mem_next.addr = pc_next;
          state_next    = S_DECODE;
        end else begin
          state_next = S_IDLE;
        end
      end
      S_LOWPWR: begin
        if (wake) begin
          osc_stop_next = 1'b0;
          clk_stop_next = 1'b0;
          state_next    = S_RESOLVE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // Software loads of the programmer's model
    if (sw_core_wr) begin
      case (wr_addr_reg)
        OFS_PC:  pc_next  = HWDATA_I[15:0];
        OFS_CCR: ccr_next = HWDATA_I[4:0];
        OFS_ACC: acc_next = HWDATA_I[7:0];
        OFS_IDX: idx_next = HWDATA_I[7:0];
        default: begin
        end
      endcase
    end
  end

  // Run bit and sticky unknown-opcode flag; a new event beats the clear
  assign run_next = ctrl_wr ? HWDATA_I[CTRL_RUN_BIT] : run_reg;
  assign bad_next = bad_set || (bad_reg && !(ctrl_wr && HWDATA_I[CTRL_CLRBAD_BIT]));
  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg    <= S_IDLE;
      pc_reg       <= START_PC;
      acc_reg      <= 8'h00;
      idx_reg      <= 8'h00;
      ccr_reg      <= CCR_RESET;
      op_reg       <= 8'h00;
      ea_reg       <= 16'h0000;
      data_reg     <= 8'h00;
      mem_reg      <= '0;
      osc_stop_reg <= 1'b0;
      clk_stop_reg <= 1'b0;
      irq_en_reg   <= 1'b0;
      run_reg      <= 1'b0;
      bad_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pc_reg       <= pc_next;
      acc_reg      <= acc_next;
      idx_reg      <= idx_next;
      ccr_reg      <= ccr_next;
      op_reg       <= op_next;
      ea_reg       <= ea_next;
      data_reg     <= data_next;
      mem_reg      <= mem_next;
      osc_stop_reg <= osc_stop_next;
      clk_stop_reg <= clk_stop_next;
      irq_en_reg   <= ~ccr_next.i;
      run_reg      <= run_next;
      bad_reg      <= bad_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------------
  // Read data is sampled at the address phase; zero wait states
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= bus_take && HWRITE_I;
      wr_addr_reg <= HADDR_I[7:0];
      hrdata_reg  <= (bus_take && !HWRITE_I) ? rd_word : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA_O       = hrdata_reg;
  assign HREADYOUT_O    = 1'b1;
  assign HRESP_O        = HRESP_OKAY;
  assign MEM_ADDR_O     = mem_reg.addr;
  assign MEM_RD_O       = mem_reg.rd;
  assign MEM_WR_O       = mem_reg.wr;
  assign MEM_WDATA_O    = mem_reg.wdata;
  assign OSC_STOP_O     = osc_stop_reg;
  assign CPU_CLK_STOP_O = clk_stop_reg;
  assign IRQ_ENABLE_O   = irq_en_reg;

endmodule : branch_bit_control_decode

/* File: dv/prog_mem_model.sv */
`timescale 1ns/1ps
// Byte memory answering within the strobe cycle
module prog_mem_model (
  input  wire logic        clk_i,   // Core clock
  input  wire logic [15:0] addr_i,  // Address
  input  wire logic        rd_i,    // Read strobe
  input  wire logic        wr_i,    // Write strobe
  input  wire logic [7:0]  wdata_i, // Write data
  output logic [7:0]       rdata_o  // Read data
);
  logic [7:0] mem [0:511];
  logic [7:0] junk_reg = 8'hA5;
  // Toggling filler off-strobe, so stale bytes never pass as valid
  assign rdata_o = rd_i ? mem[addr_i[8:0]] : junk_reg;
  always @(posedge clk_i) begin
    junk_reg <= ~junk_reg;
    if (wr_i) mem[addr_i[8:0]] <= wdata_i;
  end
endmodule : prog_mem_model

/* File: dv/branch_bit_control_decode_checker.sv */
`timescale 1ns/1ps
module branch_bit_control_decode_checker (
  input wire logic CLOCK_I, RESETN_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O, // Bus
  input wire logic MEM_RD_O, MEM_WR_O, OSC_STOP_O, CPU_CLK_STOP_O, IRQ_ENABLE_O, // Core
  input wire logic [1:0] HTRANS_I, input wire logic [31:0] HRDATA_O, // Bus
  input wire logic [15:0] MEM_ADDR_O // Memory address
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // Read of a byte then its write-back
  sequence s_rmw;
    MEM_RD_O ##1 MEM_WR_O;
  endsequence
  sequence s_no_read;
    !(HSEL_I && HTRANS_I == 2'h2 && !HWRITE_I);
  endsequence
  a_bus_zero_wait: assert property (HREADYOUT_O && !HRESP_O) else $error("bus not ready");
  a_rdata_idle_zero: assert property (s_no_read |=> HRDATA_O == 32'h0)
    else $error("read data outside data phase");
  a_stop_unmasks: assert property ($rose(OSC_STOP_O) |-> IRQ_ENABLE_O)
    else $error("stop left interrupts masked");
  a_wait_unmasks: assert property ($rose(CPU_CLK_STOP_O) |-> IRQ_ENABLE_O)
    else $error("wait left interrupts masked");
  a_lowpwr_quiet: assert property (OSC_STOP_O || CPU_CLK_STOP_O |-> !MEM_RD_O && !MEM_WR_O)
    else $error("memory access while halted");
  a_wr_pulse: assert property (MEM_WR_O |=> !MEM_WR_O)
    else $error("write strobe too long");
  a_wr_first_page: assert property (MEM_WR_O |-> MEM_ADDR_O[15:9] == 7'h00)
    else $error("write outside low page");
  a_wr_after_read: assert property (MEM_WR_O |-> $past(MEM_RD_O))
    else $error("write without read");
  a_rmw_same_addr: assert property (s_rmw |-> $stable(MEM_ADDR_O))
    else $error("write-back address moved");
endmodule : branch_bit_control_decode_checker

/* File: dv/branch_bit_control_decode_bench.sv */
`timescale 1ns/1ps
module branch_bit_control_decode_bench;
  import cpu_slice_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, wr = 0, pin = 1, hrdy, hresp, m_rd, m_wr, osc, cclk, irqen;
  logic [1:0]  trans = 2'h0;
  logic [31:0] addr = 0, wdata = 0, rq, hrdata;
  logic [15:0] m_addr;
  logic [7:0]  m_wd, m_rdat, r, s;
  logic [31:0] exp_q[$];
  int num_errors = 0, comparisons = 0, cyc = 0, seed = 49;
  event rd_ev;
  // Program: shift, move, bit set, bit branches, relative branches, stop, wait, loop
  localparam logic [7:0] PROG [0:31] = '{8'h48, 8'h97, 8'h10, 8'h60, 8'h01, 8'h60, 8'h7E,
    8'h24, 8'h10, 8'h25, 8'h02, 8'h28, 8'h05, 8'h00, 8'h60, 8'hFB, 8'h00, 8'h00, 8'h29, 8'h7F,
    8'h2E, 8'h7F, 8'h2F, 8'h02, 8'h00, 8'h00, 8'h11, 8'h60, 8'h8E, 8'h8F, 8'h20, 8'hFE};
  // Second program at 40: index shifts, direct shift, unknown opcode, loop
  localparam logic [7:0] PROG2 [0:8] = '{8'h58, 8'h68, 8'hF0, 8'h78, 8'h38, 8'h70, 8'h9D,
    8'h20, 8'hFE};
  always #2.5 clk = ~clk;
  branch_bit_control_decode i_branch_bit_control_decode (.CLOCK_I(clk), .RESETN_I(rst_n),
    .HSEL_I(sel), .HADDR_I(addr), .HTRANS_I(trans), .HWRITE_I(wr), .HSIZE_I(HSIZE_WORD),
    .HWDATA_I(wdata), .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .MEM_ADDR_O(m_addr), .MEM_RD_O(m_rd), .MEM_WR_O(m_wr), .MEM_WDATA_O(m_wd),
    .MEM_RDATA_I(m_rdat), .IRQ_PIN_I(pin), .OSC_STOP_O(osc), .CPU_CLK_STOP_O(cclk),
    .IRQ_ENABLE_O(irqen));
  prog_mem_model i_prog_mem_model (.clk_i(clk), .addr_i(m_addr), .rd_i(m_rd), .wr_i(m_wr),
    .wdata_i(m_wd), .rdata_o(m_rdat));
  task check(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check
  // Sample just before the edge, so the accepting edge never races the flops
  task phase;
    logic rdy;
    do begin
      @(negedge clk); rdy = hrdy; rq = hrdata; @(posedge clk);
    end while (rdy !== 1'b1);
  endtask : phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1; trans <= HTRANS_NONSEQ; wr <= w; addr <= {24'h0, a};
    phase();
    trans <= 2'h0; wdata <= d;
    phase();
    if (!w) ->rd_ev;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Monitor: oldest note against each read result
  always @(rd_ev) check(rq, exp_q.pop_front());
  // Watchdog against a hung core or bus
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin num_errors++; summarize(); end
  end
  task summarize;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    r = 8'($random(seed));
    s = {r[6:0], 1'b0};
    for (int i = 0; i < 512; i++) i_prog_mem_model.mem[i] = (i < 32) ? PROG[i] : 8'h00;
    for (int i = 0; i < 9; i++) i_prog_mem_model.mem[9'h040 + i] = PROG2[i];
    i_prog_mem_model.mem[9'h020] = 8'hC0;
    i_prog_mem_model.mem[9'h070] = 8'h80;
    i_prog_mem_model.mem[9'h110] = 8'h40;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CCR, 32'h08);
    bus(1'b1, OFS_ACC, {24'h0, r});
    bus(1'b1, OFS_CTRL, 32'h1);
    wait (osc === 1'b1);
    @(negedge clk);
    check({31'h0, irqen}, 32'h1);
    @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h3);
    wait (cclk === 1'b1);
    @(negedge clk);
    check({31'h0, irqen}, 32'h1);
    check({31'h0, osc}, 32'h0);
    @(posedge clk);
    pin <= 1'b0;
    wait (cclk === 1'b0);
    @(posedge clk); pin <= 1'b1;
    $display("low-power test done");
    repeat (10) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    rd(OFS_PC, 32'h1E);
    rd(OFS_CCR, {27'h0, 2'b00, s[7], s == 8'h00, 1'b1});
    rd(OFS_ACC, {24'h0, s});
    rd(OFS_IDX, {24'h0, s});
    rd(8'h40, 32'h0);
    check({24'h0, i_prog_mem_model.mem[9'h060]}, 32'h0);
    $display("program test done");
    bus(1'b1, OFS_PC, 32'h40);
    bus(1'b1, OFS_IDX, 32'h90);
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    rd(OFS_PC, 32'h47);
    rd(OFS_IDX, 32'h20);
    rd(OFS_CCR, 32'h03);
    rd(OFS_STATUS, 32'h2008);
    bus(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_STATUS, 32'h2000);
    check({24'h0, i_prog_mem_model.mem[9'h110]}, 32'h80);
    check({24'h0, i_prog_mem_model.mem[9'h020]}, 32'h80);
    check({24'h0, i_prog_mem_model.mem[9'h070]}, 32'h00);
    $display("indexed shift test done");
    // Let the monitor take the last read before the verdict
    @(posedge clk);
    summarize();
  end
endmodule : branch_bit_control_decode_bench
bind branch_bit_control_decode branch_bit_control_decode_checker i_checker (.*);
